// ### cop_pkg.sv
// Package with register map, field layout and reset values of the output path
package cop_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int VOL_W = 7;
  // Register indices; byte offsets are four times these (BYTE_SHIFT)
  localparam logic [ADDR_W-1:0] IDX_LEFT_HP = 7'h02;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_HP = 7'h03;
  localparam logic [ADDR_W-1:0] IDX_ANALOG = 7'h04;
  localparam logic [ADDR_W-1:0] IDX_DIGITAL = 7'h05;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 7'h10;
  localparam int BYTE_SHIFT = 2;
  // Headphone register fields
  localparam int HP_VOL_LSB = 0;
  localparam int HP_ZC_BIT = 7;
  localparam int HP_LINK_BIT = 8;
  localparam logic [VOL_W-1:0] VOL_MUTE_BELOW = 7'h30;
  localparam logic [VOL_W-1:0] VOL_RESET = 7'h79;
  localparam logic [VOL_W-1:0] VOL_TOP = 7'h7F;
  // Analog path register fields
  localparam int AP_LINE_BIT = 3;
  localparam int AP_CONV_BIT = 4;
  localparam int AP_MIC_BIT = 5;
  localparam int AP_ATT_LSB = 6;
  localparam logic AP_LINE_RESET = 1'b1;
  localparam logic AP_CONV_RESET = 1'b0;
  localparam logic AP_MIC_RESET = 1'b0;
  localparam logic [1:0] AP_ATT_RESET = 2'h0;
  localparam logic AP_OTHER_RESET = 1'b0;
  // Digital path register fields
  localparam int DP_SOFT_MUTE_BIT = 3;
  localparam logic DP_SOFT_MUTE_RESET = 1'b1;
  // Status register fields
  localparam int ST_LPEND_BIT = 0;
  localparam int ST_RPEND_BIT = 1;
  localparam int ST_LMUTE_BIT = 2;
  localparam int ST_RMUTE_BIT = 3;
  localparam int ST_LINE_SILENT_BIT = 4;
endpackage : cop_pkg

// ### cop_hp_channel.sv
// One headphone channel: pending volume, zero-cross gated apply, mute decode
`timescale 1ns/10ps
module cop_hp_channel (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [cop_pkg::VOL_W-1:0] loadVol,
  input wire logic loadZc,
  input wire logic nearGround,
  output logic [cop_pkg::VOL_W-1:0] writtenVol,
  output logic writtenZc,
  output logic [cop_pkg::VOL_W-1:0] activeVol,
  output logic pending,
  output logic muted
);
  typedef struct packed {
    logic [cop_pkg::VOL_W-1:0] wvol;
    logic zc;
    logic [cop_pkg::VOL_W-1:0] avol;
    logic pend;
    logic mute;
  } cop_ch_t;

  cop_ch_t state_reg;
  cop_ch_t state_next;

  function automatic logic cop_is_mute(input logic [cop_pkg::VOL_W-1:0] v);
    return v < cop_pkg::VOL_MUTE_BELOW;
  endfunction : cop_is_mute

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.wvol = loadVol;
      state_next.zc = loadZc;
      if (loadZc) begin
        state_next.pend = 1'b1;
      end else begin
        // Gate off forces immediate update, clearing any blocked change
        state_next.avol = loadVol;
        state_next.pend = 1'b0;
      end
    end else if (state_reg.pend && nearGround) begin
      // No timeout: waits forever while input sits off ground
      state_next.avol = state_reg.wvol;
      state_next.pend = 1'b0;
    end
    state_next.mute = cop_is_mute(state_next.avol);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.wvol <= cop_pkg::VOL_RESET;
      state_reg.zc <= 1'b0;
      state_reg.avol <= cop_pkg::VOL_RESET;
      state_reg.pend <= 1'b0;
      state_reg.mute <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign writtenVol = state_reg.wvol;
  assign writtenZc = state_reg.zc;
  assign activeVol = state_reg.avol;
  assign pending = state_reg.pend;
  assign muted = state_reg.mute;
endmodule : cop_hp_channel

// ### cop_output_ctrl.sv
// Output path control registers behind an APB slave
`timescale 1ns/10ps
module cop_output_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic leftNearGround,
  input wire logic rightNearGround,
  output logic [cop_pkg::VOL_W-1:0] leftPhonesGain,
  output logic [cop_pkg::VOL_W-1:0] rightPhonesGain,
  output logic leftPhonesMute,
  output logic rightPhonesMute,
  output logic lineInRouteEn,
  output logic converterToLineoutSelect,
  output logic micMonitorEn,
  output logic [1:0] micMonitorAtten,
  output logic converterSoftSilence,
  output logic lineOutSilent
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [cop_pkg::DATA_W-1:0] analog;
    logic [cop_pkg::DATA_W-1:0] digital;
    logic silent;
  } cop_top_t;

  cop_top_t state_reg;
  cop_top_t state_next;

  logic [cop_pkg::VOL_W-1:0] lWVol;
  logic [cop_pkg::VOL_W-1:0] rWVol;
  logic [cop_pkg::VOL_W-1:0] lAVol;
  logic [cop_pkg::VOL_W-1:0] rAVol;
  logic lWZc;
  logic rWZc;
  logic lPend;
  logic rPend;
  logic lMute;
  logic rMute;
  logic lLoad;
  logic rLoad;
  logic [cop_pkg::VOL_W-1:0] lLoadVol;
  logic [cop_pkg::VOL_W-1:0] rLoadVol;
  logic lLoadZc;
  logic rLoadZc;
  logic wrHit;
  logic [cop_pkg::ADDR_W-1:0] regIdx;
  logic addrOk;
  logic [cop_pkg::DATA_W-1:0] wData;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic cop_known(input logic [cop_pkg::ADDR_W-1:0] i);
    return i == cop_pkg::IDX_LEFT_HP || i == cop_pkg::IDX_RIGHT_HP ||
      i == cop_pkg::IDX_ANALOG || i == cop_pkg::IDX_DIGITAL ||
      i == cop_pkg::IDX_STATUS;
  endfunction : cop_known

  // Byte address is four times the index; nonzero low bits or high bits make the address invalid
  assign regIdx = paddr[cop_pkg::BYTE_SHIFT +: cop_pkg::ADDR_W];
  assign addrOk = cop_known(regIdx) &&
    paddr[31:cop_pkg::BYTE_SHIFT+cop_pkg::ADDR_W] == '0 &&
    paddr[cop_pkg::BYTE_SHIFT-1:0] == '0;
  assign wData = pwdata[cop_pkg::DATA_W-1:0];
  // Write commits at the edge closing the first access cycle; ready rises with it
  assign wrHit = psel && penable && !state_reg.ready && pwrite && addrOk;

  // ---------------------------------------------------------------
  // Headphone channels with linked loading
  // ---------------------------------------------------------------
  always_comb begin
    lLoad = 1'b0;
    rLoad = 1'b0;
    lLoadVol = wData[cop_pkg::HP_VOL_LSB +: cop_pkg::VOL_W];
    rLoadVol = wData[cop_pkg::HP_VOL_LSB +: cop_pkg::VOL_W];
    lLoadZc = wData[cop_pkg::HP_ZC_BIT];
    rLoadZc = wData[cop_pkg::HP_ZC_BIT];
    if (wrHit && regIdx == cop_pkg::IDX_LEFT_HP) begin
      lLoad = 1'b1;
      rLoad = wData[cop_pkg::HP_LINK_BIT];
    end else if (wrHit && regIdx == cop_pkg::IDX_RIGHT_HP) begin
      rLoad = 1'b1;
      lLoad = wData[cop_pkg::HP_LINK_BIT];
    end
  end

  cop_hp_channel uLeft (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(lLoad),
    .loadVol(lLoadVol),
    .loadZc(lLoadZc),
    .nearGround(leftNearGround),
    .writtenVol(lWVol),
    .writtenZc(lWZc),
    .activeVol(lAVol),
    .pending(lPend),
    .muted(lMute)
  );

  cop_hp_channel uRight (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(rLoad),
    .loadVol(rLoadVol),
    .loadZc(rLoadZc),
    .nearGround(rightNearGround),
    .writtenVol(rWVol),
    .writtenZc(rWZc),
    .activeVol(rAVol),
    .pending(rPend),
    .muted(rMute)
  );

  // ---------------------------------------------------------------
  // Register file and bus answer
  // ---------------------------------------------------------------
  function automatic logic [31:0] cop_read(
    input logic [cop_pkg::ADDR_W-1:0] i,
    input cop_top_t s
  );
    logic [31:0] r;
    r = '0;
    case (i)
      cop_pkg::IDX_LEFT_HP: begin
        r[cop_pkg::HP_VOL_LSB +: cop_pkg::VOL_W] = lWVol;
        r[cop_pkg::HP_ZC_BIT] = lWZc;
      end
      cop_pkg::IDX_RIGHT_HP: begin
        r[cop_pkg::HP_VOL_LSB +: cop_pkg::VOL_W] = rWVol;
        r[cop_pkg::HP_ZC_BIT] = rWZc;
      end
      cop_pkg::IDX_ANALOG: r[cop_pkg::DATA_W-1:0] = s.analog;
      cop_pkg::IDX_DIGITAL: r[cop_pkg::DATA_W-1:0] = s.digital;
      cop_pkg::IDX_STATUS: begin
        r[cop_pkg::ST_LPEND_BIT] = lPend;
        r[cop_pkg::ST_RPEND_BIT] = rPend;
        r[cop_pkg::ST_LMUTE_BIT] = lMute;
        r[cop_pkg::ST_RMUTE_BIT] = rMute;
        r[cop_pkg::ST_LINE_SILENT_BIT] = s.silent;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : cop_read

  always_comb begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.err = 1'b0;
    // Read data shows only in the answer cycle, zero otherwise
    state_next.rdata = '0;
    if (psel && penable && !state_reg.ready) begin
      // One wait state: answer in the second access cycle
      state_next.ready = 1'b1;
      state_next.err = !addrOk;
      state_next.rdata = (!pwrite && addrOk) ? cop_read(regIdx, state_reg)
                                             : '0;
    end
    if (wrHit && regIdx == cop_pkg::IDX_ANALOG) begin
      state_next.analog = wData;
    end
    if (wrHit && regIdx == cop_pkg::IDX_DIGITAL) begin
      state_next.digital = wData;
    end
    // Sources sum; silence needs converter muted or deselected and both analog paths off
    state_next.silent = (state_next.digital[cop_pkg::DP_SOFT_MUTE_BIT] ||
      !state_next.analog[cop_pkg::AP_CONV_BIT]) &&
      !state_next.analog[cop_pkg::AP_LINE_BIT] &&
      !state_next.analog[cop_pkg::AP_MIC_BIT];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.rdata <= '0;
      state_reg.ready <= 1'b0;
      state_reg.err <= 1'b0;
      state_reg.analog <= '0;
      state_reg.analog[cop_pkg::AP_LINE_BIT] <= cop_pkg::AP_LINE_RESET;
      state_reg.analog[cop_pkg::AP_CONV_BIT] <= cop_pkg::AP_CONV_RESET;
      state_reg.analog[cop_pkg::AP_MIC_BIT] <= cop_pkg::AP_MIC_RESET;
      state_reg.analog[cop_pkg::AP_ATT_LSB +: 2] <= cop_pkg::AP_ATT_RESET;
      state_reg.digital <= '0;
      state_reg.digital[cop_pkg::DP_SOFT_MUTE_BIT] <=
        cop_pkg::DP_SOFT_MUTE_RESET;
      state_reg.silent <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign leftPhonesGain = lAVol;
  assign rightPhonesGain = rAVol;
  assign leftPhonesMute = lMute;
  assign rightPhonesMute = rMute;
  assign lineInRouteEn = state_reg.analog[cop_pkg::AP_LINE_BIT];
  assign converterToLineoutSelect = state_reg.analog[cop_pkg::AP_CONV_BIT];
  assign micMonitorEn = state_reg.analog[cop_pkg::AP_MIC_BIT];
  assign micMonitorAtten = state_reg.analog[cop_pkg::AP_ATT_LSB +: 2];
  assign converterSoftSilence = state_reg.digital[cop_pkg::DP_SOFT_MUTE_BIT];
  assign lineOutSilent = state_reg.silent;
endmodule : cop_output_ctrl

// ### cop_output_ctrl_monitor.sv
// Concurrent checks on the output path control block ports
`timescale 1ns/10ps
module cop_output_ctrl_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [cop_pkg::VOL_W-1:0] leftPhonesGain,
  input wire logic [cop_pkg::VOL_W-1:0] rightPhonesGain,
  input wire logic leftPhonesMute,
  input wire logic rightPhonesMute,
  input wire logic lineInRouteEn,
  input wire logic converterToLineoutSelect,
  input wire logic micMonitorEn,
  input wire logic converterSoftSilence,
  input wire logic lineOutSilent
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Helper capture of the accepted write code
  // ----------------------------------------
  logic [cop_pkg::VOL_W-1:0] wrVol_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      wrVol_reg <= '0;
    else if (psel && penable && !pready)
      wrVol_reg <= pwdata[6:0];
  end
  sequence sTake;
    psel && penable && !pready;
  endsequence
  sequence sLeftImm;
    sTake ##0 (pwrite && paddr == 32'h8 && !pwdata[7]);
  endsequence
  a_take_answer: assert property (sTake |=> pready)
    else $error("no answer after access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_misalign_err: assert property (
    sTake ##0 (paddr[1:0] != 2'h0) |=> pslverr)
    else $error("misaligned access not refused");
  a_left_direct: assert property (
    sLeftImm |-> ##[1:2] leftPhonesGain == wrVol_reg)
    else $error("ungated left write not applied");
  a_left_mute: assert property (
    leftPhonesMute == (leftPhonesGain < cop_pkg::VOL_MUTE_BELOW))
    else $error("left mute decode wrong");
  a_right_mute: assert property (
    rightPhonesMute == (rightPhonesGain < cop_pkg::VOL_MUTE_BELOW))
    else $error("right mute decode wrong");
  // Silence flag registers in the same edge as the path bits
  a_silent_map: assert property ($stable({converterSoftSilence,
    converterToLineoutSelect, lineInRouteEn, micMonitorEn}) |->
    lineOutSilent == ((converterSoftSilence || !converterToLineoutSelect)
    && !lineInRouteEn && !micMonitorEn))
    else $error("line out silence decode wrong");
endmodule : cop_output_ctrl_monitor
bind cop_output_ctrl cop_output_ctrl_monitor u_mon (.*);

// ### cop_host_model.sv
// Host processor model: APB master for the control registers
`timescale 1ns/10ps
module cop_host_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e,
    output logic to);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    to = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old request
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : cop_host_model

// ### cop_output_ctrl_tb.sv
// Self-checking bench for the output path control block
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module cop_output_ctrl_tb;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic leftNearGround, rightNearGround, leftPhonesMute, rightPhonesMute;
  logic [cop_pkg::VOL_W-1:0] leftPhonesGain, rightPhonesGain;
  logic lineInRouteEn, converterToLineoutSelect, micMonitorEn, rerr;
  logic converterSoftSilence, lineOutSilent;
  logic [1:0] micMonitorAtten;
  int badCount, nCompared;
  cop_output_ctrl DUT (.*);
  cop_host_model host (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] ba(input logic [6:0] i);
    return {23'h0, i, 2'h0};
  endfunction : ba
  task automatic summarize;
    $display("Mismatches %0d, compares %0d", badCount, nCompared);
    if (badCount == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic acc(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    logic to;
    host.xfer(w, a, d, rdat, rerr, to);
    if (to) begin
      badCount++;
      summarize();
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask : acc
  task automatic ground(input logic l, input logic r);
    @(posedge core_clk);
    leftNearGround <= l;
    rightNearGround <= r;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : ground
  task automatic t_reset;
    @(posedge core_clk);
    #1;
    `CHK({leftPhonesGain, rightPhonesGain}, 14'h3CF9)
    `CHK({leftPhonesMute, rightPhonesMute}, 2'h0)
    `CHK(lineInRouteEn, 1'b1)
    `CHK({converterToLineoutSelect, micMonitorEn}, 2'h0)
    `CHK(micMonitorAtten, 2'h0)
    `CHK({converterSoftSilence, lineOutSilent}, 2'h2)
    acc(1'b0, ba(cop_pkg::IDX_RIGHT_HP), 32'h0);
    `CHK(rdat, 32'h079)
    acc(1'b0, ba(cop_pkg::IDX_ANALOG), 32'h0);
    `CHK(rdat, 32'h008)
    acc(1'b0, ba(cop_pkg::IDX_DIGITAL), 32'h0);
    `CHK(rdat[3], 1'b1)
  endtask : t_reset
  task automatic t_volume;
    logic [6:0] codes [4] = '{7'h7F, 7'h30, 7'h2F, 7'h00};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), {25'h0, codes[i]});
      `CHK(leftPhonesGain, codes[i])
      `CHK(leftPhonesMute, codes[i] < 7'h30)
      `CHK(rightPhonesMute, 1'b0)
    end
    acc(1'b0, ba(cop_pkg::IDX_LEFT_HP), 32'h0);
    `CHK(rdat, 32'h000)
  endtask : t_volume
  task automatic t_zc;
    acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), 32'h0C0);
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(leftPhonesGain, 7'h00)
    acc(1'b0, ba(cop_pkg::IDX_STATUS), 32'h0);
    `CHK(rdat[0], 1'b1)
    acc(1'b0, ba(cop_pkg::IDX_LEFT_HP), 32'h0);
    `CHK(rdat, 32'h0C0)
    // Same code with gating off clears the blocked change
    acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), 32'h040);
    `CHK(leftPhonesGain, 7'h40)
    acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), 32'h0D5);
    `CHK(leftPhonesGain, 7'h40)
    ground(1'b1, 1'b0);
    `CHK(leftPhonesGain, 7'h55)
    ground(1'b0, 1'b0);
  endtask : t_zc
  task automatic t_link;
    acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), 32'h166);
    `CHK({leftPhonesGain, rightPhonesGain}, 14'h3366)
    acc(1'b1, ba(cop_pkg::IDX_RIGHT_HP), 32'h160);
    `CHK({leftPhonesGain, rightPhonesGain}, 14'h3060)
    acc(1'b0, ba(cop_pkg::IDX_RIGHT_HP), 32'h0);
    `CHK(rdat, 32'h060)
    acc(1'b1, ba(cop_pkg::IDX_RIGHT_HP), 32'h1B0);
    ground(1'b0, 1'b1);
    `CHK({leftPhonesGain, rightPhonesGain}, 14'h3030)
    ground(1'b1, 1'b0);
    `CHK({leftPhonesGain, leftPhonesMute}, 8'h60)
    ground(1'b0, 1'b0);
  endtask : t_link
  task automatic t_route;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, ba(cop_pkg::IDX_ANALOG), {24'h0, k[1:0], 6'h08});
      `CHK(micMonitorAtten, k[1:0])
    end
    acc(1'b1, ba(cop_pkg::IDX_ANALOG), 32'h008);
    `CHK({lineInRouteEn, converterToLineoutSelect, micMonitorEn}, 3'h4)
    `CHK(lineOutSilent, 1'b0)
    acc(1'b1, ba(cop_pkg::IDX_LEFT_HP), 32'h020);
    `CHK({leftPhonesGain, leftPhonesMute}, 8'h41)
    acc(1'b1, ba(cop_pkg::IDX_ANALOG), 32'h020);
    `CHK({micMonitorEn, lineInRouteEn, lineOutSilent}, 3'h4)
    acc(1'b1, ba(cop_pkg::IDX_ANALOG), 32'h010);
    `CHK({converterToLineoutSelect, lineOutSilent}, 2'h3)
    acc(1'b1, ba(cop_pkg::IDX_DIGITAL), 32'h000);
    `CHK({converterSoftSilence, lineOutSilent}, 2'h0)
    acc(1'b1, ba(cop_pkg::IDX_DIGITAL), 32'h008);
    `CHK({converterSoftSilence, lineOutSilent}, 2'h3)
  endtask : t_route
  task automatic t_err;
    acc(1'b0, 32'h7C, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    acc(1'b1, 32'h9, 32'h07F);
    `CHK({rerr, leftPhonesGain}, 8'hA0)
    acc(1'b1, ba(cop_pkg::IDX_STATUS), 32'h0);
    `CHK(rerr, 1'b0)
  endtask : t_err
  initial begin
    reset_n = 1'b0;
    leftNearGround = 1'b0;
    rightNearGround = 1'b0;
    badCount = 0;
    nCompared = 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_volume();
    t_zc();
    t_link();
    t_route();
    t_err();
    // Second reset in mid-run must restore every field
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    summarize();
  end
endmodule : cop_output_ctrl_tb
